// File: core/eeprom_serial_core.sv
// Two-wire serial EEPROM slave: page write, ack polling and reads
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: A page write programs one to sixteen bytes, all within one row.
// RULE2: Extra data bytes after the first are each acked every ninth clock.
// RULE3: STOP after loaded data starts self-timed programming, at most 5 ms.
// RULE4: Each data byte advances only the low 4 column bits of the address.
// RULE5: A page load may start at any column of the row.
// RULE6: Beyond sixteen bytes the column wraps and overwrites earlier bytes.
// RULE7: While programming, device address bytes are left unacknowledged.
// RULE8: Once programming ends, a matching device address is acknowledged.
// RULE9: Read uses the same address byte with the last bit set to one.
// RULE10: The address counter holds last accessed address plus one.
// RULE11: Current read acks, sends the byte at the counter, then increments.
// RULE12: Controller ends a current read with no ack and a STOP.
// RULE13: Each controller ack during reading fetches the next byte.
// RULE14: The read counter wraps from the top address to address zero.
// RULE15: Controller ends a sequential read with no ack then STOP.
// RULE16: Random read is a dummy write of the address then a new read.
// RULE17: START after the word address drops the write, keeping the address.
// RULE18: Respond only to type 1010 and matching chip select pins.
// RULE19: Each received byte is acked by pulling data low on clock nine.
// RULE20: Data sampled on clock rise, driven after clock fall.
// RULE21: Write protect high inhibits programming; reads unaffected.
// RULE22: After a refused address, stay released until the next START.
module eeprom_serial_core
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  // Reference clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Two-wire link
  input wire logic i_scl_clk,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Straps
  input wire logic [2:0] i_chip_select_address_pins,
  input wire logic i_write_protect,
  // Status
  output logic o_busy
);

  localparam logic [PROG_CNT_W-1:0] PROG_LAST =
    PROG_CNT_W'(PROG_CYCLES_P - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: receive shift register

  logic [7:0] link_shift;

  // Samples on every clock rise; frames are tracked on the reference side
  always_ff @(posedge i_scl_clk) begin
    link_shift <= {link_shift[6:0], i_sda_i}; // RULE20
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filtering

  logic [5:0] pin_raw;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_f;
  logic [5:0] pin_q;
  logic [5:0] next_pin_f;

  assign pin_raw = {i_write_protect, i_chip_select_address_pins,
                    i_scl_clk, i_sda_i};

  // A bit changes only once the second and third stages agree
  assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
      pin_f <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      pin_q <= pin_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events

  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic [2:0] cs_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_f = pin_f[1];
  assign sda_f = pin_f[0];
  assign wp_f = pin_f[5];
  assign cs_f = pin_f[4:2];
  assign scl_rise = scl_f & ~pin_q[1];
  assign scl_fall = ~scl_f & pin_q[1];
  assign start_ev = scl_f & pin_q[1] & ~sda_f & pin_q[0];
  assign stop_ev = scl_f & pin_q[1] & sda_f & ~pin_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state

  link_state_t state;
  link_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic ack_pend;
  logic next_ack_pend;
  logic rd_first;
  logic next_rd_first;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic [15:0] valid;
  logic [15:0] next_valid;
  logic oe;
  logic next_oe;

  logic busy;
  logic [PROG_CNT_W-1:0] prog_cnt;
  logic [15:0] prog_mask;

  logic [7:0] rx_byte;
  logic [7:0] arr_rdata;
  logic [7:0] buf_rdata;
  logic [3:0] col;
  logic [3:0] col_next;
  logic active;
  logic byte_done;
  logic dev_ok;
  logic tx_bit;
  logic commit;

  // Link word is stable for a whole clock period after its last rise
  assign rx_byte = link_shift;
  assign col = addr[3:0];
  assign col_next = col + 4'h1; // RULE4 RULE6
  assign active = (state != ST_IDLE);
  assign byte_done = active && scl_rise && (cnt == BIT_LAST);

  assign dev_ok = (rx_byte[7:4] == DEV_TYPE_CODE) &&
                  (rx_byte[3:1] == cs_f); // RULE18

  // Serial bit of the byte now being sent, msb first; the msb leaves on
  // the fall that closes the ack slot, while cnt still reads nine
  assign tx_bit = (cnt == BIT_END) ? arr_rdata[7] :
                  arr_rdata[3'(BIT_LAST - cnt)];

  // Only a write with data loaded and protect low programs
  assign commit = stop_ev && (state == ST_WDATA) && (|valid) &&
                  !busy && !wp_f; // RULE3 RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ack_pend = ack_pend;
    next_rd_first = rd_first;
    next_addr = addr;
    next_valid = valid;
    next_oe = oe;
    if (start_ev) begin
      // Abandon any pending write; the address counter is kept
      next_state = ST_DEV; // RULE17
      next_cnt = BIT_FIRST;
      next_oe = 1'b0;
      next_valid = VALID_RST; // RULE17
    end else if (stop_ev) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else if (active && scl_rise) begin
      next_cnt = cnt + 4'h1;
      if (cnt == BIT_LAST) begin
        case (state)
          ST_DEV: begin
            if (dev_ok && !busy) begin
              next_ack_pend = 1'b1; // RULE8
              next_rd_first = 1'b1;
              if (rx_byte[0]) begin
                next_state = ST_READ; // RULE9
              end else begin
                next_state = ST_WADDR;
              end
            end else begin
              next_ack_pend = 1'b0; // RULE7
              next_state = ST_IDLE; // RULE22
            end
          end
          ST_WADDR: begin
            next_addr = rx_byte; // RULE16
            next_valid = VALID_RST;
            next_ack_pend = 1'b1;
            next_state = ST_WDATA;
          end
          ST_WDATA: begin
            // Row bits hold; column may start anywhere and wraps
            next_addr = {addr[7:4], col_next}; // RULE4 RULE5 RULE6
            next_valid[col] = 1'b1; // RULE1
            next_ack_pend = 1'b1; // RULE2
          end
          ST_READ: begin
            next_addr = addr + 8'h01; // RULE11 RULE14 RULE10
            next_ack_pend = 1'b0;
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end else if (cnt == BIT_ACK && state == ST_READ) begin
        next_rd_first = 1'b0;
        // Controller no-ack ends the read; wait for the STOP
        if (!rd_first && sda_f) begin
          next_state = ST_IDLE; // RULE12 RULE15
        end
      end
    end else if (active && scl_fall) begin
      if (cnt == BIT_ACK) begin
        next_oe = ack_pend; // RULE19 RULE2
      end else if (cnt == BIT_END) begin
        next_cnt = BIT_FIRST;
        // Controller ack fetches the next byte at the new counter
        next_oe = (state == ST_READ) && !tx_bit; // RULE13 RULE11
      end else begin
        next_oe = (state == ST_READ) && !tx_bit; // RULE20
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      cnt <= BIT_FIRST;
      ack_pend <= 1'b0;
      rd_first <= 1'b0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ack_pend <= next_ack_pend;
      rd_first <= next_rd_first;
      oe <= next_oe;
    end
  end

  // Counter survives everything but power-up
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr <= ADDR_RST;
      valid <= VALID_RST;
    end else begin
      addr <= next_addr; // RULE10
      valid <= next_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed programming

  logic prog_done;
  logic copy_we;
  logic [3:0] copy_col;

  assign prog_done = busy && (prog_cnt == PROG_LAST);
  assign copy_col = 4'(prog_cnt - 1'b1);
  // Copy runs in the first cycles of the program time
  assign copy_we = busy && (prog_cnt != '0) &&
                   (prog_cnt <= PROG_CNT_W'(COPY_LAST)) &&
                   prog_mask[copy_col];

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      busy <= 1'b0;
      prog_cnt <= '0;
      prog_mask <= VALID_RST;
    end else if (commit) begin
      busy <= 1'b1; // RULE3
      prog_cnt <= '0;
      prog_mask <= valid;
    end else if (busy) begin
      prog_cnt <= prog_cnt + 1'b1;
      if (prog_done) begin
        busy <= 1'b0; // RULE3 RULE8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer and array

  logic buf_we;
  logic [3:0] buf_raddr;

  assign buf_we = byte_done && (state == ST_WDATA);
  assign buf_raddr = prog_cnt[3:0];

  byte_mem #(
    .AW(COL_W)
  ) u_page_buf (
    .i_ref_clk(i_ref_clk),
    .i_we(buf_we),
    .i_waddr(col),
    .i_wdata(rx_byte),
    .i_raddr(buf_raddr),
    .o_rdata(buf_rdata)
  );

  // Loaded columns of the page land in the row that the counter points at
  byte_mem #(
    .AW(ADDR_W)
  ) u_array (
    .i_ref_clk(i_ref_clk),
    .i_we(copy_we),
    .i_waddr({addr[7:4], copy_col}), // RULE1
    .i_wdata(buf_rdata),
    .i_raddr(addr),
    .o_rdata(arr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: only ever pulls low
  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe;
  assign o_busy = busy;

endmodule

`default_nettype wire

// File: core/eeprom_pkg.sv
// Constants, state codes and timing for the serial EEPROM slave core
package eeprom_pkg;

  // Device type code in the top nibble of the address byte
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;

  // Array geometry
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned COL_W = 4;
  localparam int unsigned ROW_BYTES = 16;

  // Self-timed program time and its cycle count at the reference clock
  localparam int unsigned WR_TIME_MS = 5;
  localparam int unsigned REF_CLK_KHZ = 40_000;
  localparam int unsigned PROG_CYCLES = WR_TIME_MS * REF_CLK_KHZ;
  localparam int unsigned PROG_CNT_W = 18;

  // Bit counter marks within one nine-clock frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // Copy window of the page buffer into the array
  localparam logic [4:0] COPY_LAST = 5'h10;

  // Values after reset; pin vector is {wp, cs[2:0], scl, sda}
  localparam logic [5:0] PIN_RST = 6'h03;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [15:0] VALID_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_READ = 3'b100
  } link_state_t;

endpackage

// File: core/byte_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module byte_mem #(
  parameter int unsigned AW = 8
) (
  // Clock
  input wire logic i_ref_clk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Contents are not reset; cells hold what was last programmed
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

// File: dv/eeprom_serial_checker.sv
// Port assertions for the serial EEPROM core
`timescale 1ns/1ps
`default_nettype none
module eeprom_serial_checker
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_scl_clk,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic [2:0] i_chip_select_address_pins,
  input wire logic i_write_protect,
  input wire logic o_busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic [PROG_CNT_W-1:0] bcnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !o_busy)
      bcnt <= '0;
    else
      bcnt <= bcnt + 1'b1;
  end
  sequence s_ack_on;
    $rose(o_sda_oe);
  endsequence
  sequence s_prog_end;
    $fell(o_busy);
  endsequence
  a_sda_low: assert property (o_sda_o == 1'b0)
    else $error("data value not low");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_srst |=> !o_sda_oe && !o_busy) else $error("reset not quiet");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl_clk)
    else $error("data drive changed with clock high");
  a_ack_holds: assert property (s_ack_on |=> o_sda_oe [*6])
    else $error("drive low too short");
  a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
    else $error("ack while programming");
  a_prog_time: assert property (s_prog_end |->
    bcnt >= PROG_CYCLES_P - 1 && bcnt <= PROG_CYCLES_P)
    else $error("program time wrong");
  a_prog_stop: assert property (
    $rose(o_busy) |-> i_scl_clk && i_sda_i)
    else $error("program not after stop");
  a_wp_inhibit: assert property (
    $rose(o_busy) |-> !$past(i_write_protect, 12))
    else $error("program while protected");
endmodule
bind eeprom_serial_core eeprom_serial_checker #(
  .PROG_CYCLES_P(PROG_CYCLES_P)
) i_chk (
  .i_ref_clk,
  .i_srst,
  .i_scl_clk,
  .i_sda_i,
  .o_sda_o,
  .o_sda_oe,
  .i_chip_select_address_pins,
  .i_write_protect,
  .o_busy
);
`default_nettype wire

// File: dv/eeprom_bus_ctl.sv
// Two-wire bus controller model
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_ctl (
  // Clock and resolved wire
  input wire logic i_ref_clk,
  input wire logic i_sda,
  // Lines; data 1 means released to the pull-up
  output logic o_scl,
  output logic o_sda
);
  int hp = 12;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Clock stands low between frames and high only after a stop
  task automatic start();
    o_sda <= 1'b1;
    wt(hp);
    o_scl <= 1'b1;
    wt(hp);
    o_sda <= 1'b0;
    wt(hp);
    o_scl <= 1'b0;
    wt(4);
  endtask
  task automatic stop();
    o_sda <= 1'b0;
    wt(hp);
    o_scl <= 1'b1;
    wt(hp);
    o_sda <= 1'b1;
    wt(hp);
  endtask
  // Data moves only after a few cycles of clock low
  task automatic bit_x(input logic b, output logic r);
    o_sda <= b;
    wt(hp);
    o_scl <= 1'b1;
    wt(hp);
    r = i_sda;
    o_scl <= 1'b0;
    wt(4);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!ack, r);
  endtask
endmodule
`default_nettype wire

// File: dv/test_serial_eeprom_page_write_and_read.sv
// Self-checking bench for the serial EEPROM core
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_page_write_and_read;
  import eeprom_pkg::*;
  localparam int unsigned PROG = 600;
  localparam logic [2:0] CS = 3'h5;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] cs_pins = CS;
  logic a;
  logic [7:0] q [16];
  int err_count = 0;
  int checked = 0;
  wire scl, ctl_sda, sda_w, sda_o, sda_oe, busy;
  // Open-drain wire with pull-up
  assign sda_w = (sda_oe && !sda_o) ? 1'b0 : ctl_sda;
  eeprom_serial_core #(.PROG_CYCLES_P(PROG)) i_dut (
    .i_ref_clk(clk), .i_srst(srst), .i_scl_clk(scl), .i_sda_i(sda_w),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_chip_select_address_pins(cs_pins), .i_write_protect(wp),
    .o_busy(busy));
  eeprom_bus_ctl i_ctl (.i_ref_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda(ctl_sda));
  always #12.5 clk = ~clk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic dev(input logic rw);
    i_ctl.start();
    i_ctl.tx({DEV_TYPE_CODE, CS, rw}, a);
  endtask
  task automatic prog_wait(input logic exp);
    repeat (20) @(posedge clk);
    chk("busy", busy, exp);
    if (exp) begin
      dev(1'b0);
      chk("poll busy", a, 0);
      i_ctl.stop();
      repeat (PROG) @(posedge clk);
      dev(1'b0);
      chk("poll done", a, 1);
      i_ctl.stop();
    end
  endtask
  task automatic wr(logic [7:0] adr, int n, logic [7:0] d0);
    dev(1'b0);
    chk("dev ack", a, 1);
    i_ctl.tx(adr, a);
    chk("word ack", a, 1);
    for (int i = 0; i < n; i++) begin
      i_ctl.tx(d0 + i[7:0], a);
      chk("data ack", a, 1);
    end
    i_ctl.stop();
  endtask
  task automatic seq(int n);
    dev(1'b1);
    chk("read ack", a, 1);
    for (int i = 0; i < n; i++)
      i_ctl.rx(i < n - 1, q[i]);
    i_ctl.stop();
  endtask
  task automatic rrd(logic [7:0] adr, int n);
    dev(1'b0);
    i_ctl.tx(adr, a);
    seq(n);
  endtask
  task automatic t_page();
    wr(8'h3e, 18, 8'h40);
    prog_wait(1'b1);
    rrd(8'h30, 15);
    for (int c = 0; c < 15; c++)
      chk("page", q[c], c < 14 ? 8'h42 + c[7:0] : 8'h50);
    seq(1);
    chk("current", q[0], 8'h51);
  endtask
  task automatic t_wrap();
    wr(8'hff, 1, 8'h77);
    prog_wait(1'b1);
    wr(8'h00, 1, 8'h88);
    prog_wait(1'b1);
    i_ctl.hp = 20;
    rrd(8'hff, 2);
    i_ctl.hp = 12;
    chk("top", q[0], 8'h77);
    chk("wrap", q[1], 8'h88);
  endtask
  task automatic t_wp_abort();
    @(posedge clk);
    wp <= 1'b1;
    wr(8'h00, 1, 8'h11);
    prog_wait(1'b0);
    @(posedge clk);
    wp <= 1'b0;
    dev(1'b0);
    i_ctl.tx(8'hff, a);
    seq(2);
    chk("abort busy", busy, 0);
    chk("abort addr", q[0], 8'h77);
    chk("protected", q[1], 8'h88);
  endtask
  task automatic t_refuse();
    logic [7:0] bad [2];
    bad = '{{4'hb, CS, 1'b0}, {DEV_TYPE_CODE, CS ^ 3'h1, 1'b0}};
    for (int i = 0; i < 2; i++) begin
      i_ctl.start();
      i_ctl.tx(bad[i], a);
      chk("refused", a, 0);
      i_ctl.tx(8'h00, a);
      chk("ignored", a, 0);
      i_ctl.stop();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_refuse();
    t_page();
    t_wrap();
    t_wp_abort();
    give_verdict();
  end
  // Run needs roughly 21000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
